// *** design/adc_regs_cfg.svh ***
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH

// byte addresses of the register words on the bus
`define ADR_STATUS_CTRL  5'h00
`define ADR_RESULT_HIGH  5'h04
`define ADR_RESULT_LOW   5'h08
`define ADR_CMP_HIGH     5'h0c
`define ADR_CMP_LOW      5'h10
`define ADR_CONV_CONFIG  5'h14
`define ADR_PIN_SELECT   5'h18

// status and control field positions
`define SC_FLAG_BIT      7
`define SC_IRQ_EN_BIT    6
`define SC_CMP_EN_BIT    5
`define SC_CMP_GE_BIT    4

// conversion configuration field positions
`define CFG_LOW_PWR_BIT  7
`define CFG_DIV_MSB      6
`define CFG_DIV_LSB      5
`define CFG_LONG_SMP_BIT 4
`define CFG_MODE_MSB     3
`define CFG_MODE_LSB     2
`define CFG_CLK_MSB      1
`define CFG_CLK_LSB      0

// encodings and reset values
`define MODE_TEN_BIT     2'h2
`define RST_CONFIG       8'h00
`define RST_CMP          8'h00
`define RST_PINS         8'h00
`define RST_RESULT       8'h00
`define RES_MAX_TEN      10'h3ff
`define RES_MAX_EIGHT    8'hff

`endif

// *** design/adc_regs_pkg.sv ***
`default_nettype none

package adc_regs_pkg;

  // bus handshake phases
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  // divider input clock source
  typedef enum logic [1:0] {
    CLK_BUS      = 2'h0,
    CLK_BUS_HALF = 2'h1,
    CLK_ALT      = 2'h2,
    CLK_ASYNC    = 2'h3
  } clk_src_t;

  typedef struct packed {
    bus_state_t bus_st;
    logic       ack;
    logic [7:0] rdata;
    logic [1:0] res_hi;
    logic [7:0] res_lo;
    logic [1:0] cmp_hi;
    logic [7:0] cmp_lo;
    logic [7:0] cfg;
    logic [7:0] pins;
    logic       irq_en;
    logic       cmp_en;
    logic       cmp_ge;
    logic       flag;
    logic       lock;
    logic       irq;
    logic       ten_mode;
  } regs_state_t;

  typedef struct packed {
    logic       half;
    logic [2:0] cnt;
    logic       en;
  } clkgen_state_t;

endpackage

`default_nettype wire

// *** design/result_shaper.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_cfg.svh"

// rounds the raw converter word and evaluates the compare condition
module result_shaper (
  input  wire logic [10:0] raw_i,
  input  wire logic        ten_bit_i,
  input  wire logic [1:0]  cmp_hi_i,
  input  wire logic [7:0]  cmp_lo_i,
  input  wire logic        cmp_ge_i,
  output logic      [9:0]  res_o,
  output logic             cmp_true_o
);
  import adc_regs_pkg::*;

  logic [10:0] sum_ten;
  logic [8:0]  sum_eight;
  logic [9:0]  cmp_val;

  // round half up, saturating so an all-ones raw word cannot wrap to zero
  always_comb begin
    sum_ten   = {1'b0, raw_i[10:1]} + {10'h000, raw_i[0]};
    sum_eight = {1'b0, raw_i[8:1]} + {8'h00, raw_i[0]};
    if (ten_bit_i) begin
      res_o = sum_ten[10] ? `RES_MAX_TEN : sum_ten[9:0];
    end else begin
      res_o = {2'h0, sum_eight[8] ? `RES_MAX_EIGHT : sum_eight[7:0]};
    end
    // upper compare bits only take part in ten-bit mode
    cmp_val = ten_bit_i ? {cmp_hi_i, cmp_lo_i} : {2'h0, cmp_lo_i};
    cmp_true_o = cmp_ge_i ? (res_o >= cmp_val) : (res_o < cmp_val);
  end

endmodule
`default_nettype wire

// *** design/conv_clock_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_cfg.svh"

// converter clock as a one-cycle enable: source select, then divide
module conv_clock_gen (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire adc_regs_pkg::clk_src_t src_i,
  input  wire logic [1:0]            div_i,
  input  wire logic                  alt_en_i,
  input  wire logic                  async_en_i,
  output logic                       clk_en_o
);
  import adc_regs_pkg::*;

  clkgen_state_t s_q;
  clkgen_state_t s_d;
  logic          tick;
  logic [2:0]    last;

  // pick the source pulse and count it down by 1, 2, 4 or 8
  always_comb begin
    s_d = s_q;
    s_d.half = ~s_q.half;
    case (src_i)
      CLK_BUS:      tick = 1'b1;
      CLK_BUS_HALF: tick = s_q.half;
      CLK_ALT:      tick = alt_en_i;
      CLK_ASYNC:    tick = async_en_i;
      default:      tick = 1'b0;
    endcase
    case (div_i)
      2'h0:    last = 3'h0;
      2'h1:    last = 3'h1;
      2'h2:    last = 3'h3;
      default: last = 3'h7;
    endcase
    s_d.en = 1'b0;
    if (tick) begin
      // a shrinking divide ratio restarts cleanly instead of wrapping
      if (s_q.cnt >= last) begin
        s_d.cnt = 3'h0;
        s_d.en  = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_en_o = s_q.en;

endmodule
`default_nettype wire

// *** design/adc_regs_top.sv ***
// How it works
// - result high shows top two bits; zero in eight-bit
// - completion loads result unless compare fails
// - ten-bit high read locks until low read
// - completions while locked are dropped
// - eight-bit mode has no read lock
// - result low holds low eight bits
// - ten-bit compare uses compare high bits
// - eight-bit compare ignores compare high
// - compare low meets low eight result bits
// - config bit 7 picks low power
// - config bits 6:5 divide by 1,2,4,8
// - config bit 4 picks long sample
// - config bits 3:2 pick conversion width
// - config bits 1:0 pick divider input clock
// - pin select bit n frees channel n pin
// - compare: below, or greater-or-equal when set
// - status bit 5 enables automatic compare
// - loaded result sets flag, interrupt if enabled
// - round to ten bits, or eight into low
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_cfg.svh"

module adc_regs_top (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [4:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   conv_done_i,
  input  wire logic [10:0]            conv_raw_i,
  input  wire logic                   alt_clk_en_i,
  input  wire logic                   async_clk_en_i,
  output logic                        converter_clock_en_o,
  output var adc_regs_pkg::clk_src_t  input_clock_select_o,
  output logic                        low_power_select_o,
  output logic                        long_sample_select_o,
  output logic                        ten_bit_mode_o,
  output logic      [7:0]             pin_disable_o,
  output logic                        complete_irq_o
);
  import adc_regs_pkg::*;

  regs_state_t s_q;
  regs_state_t s_d;
  logic [9:0]  shaped;
  logic        cmp_true;
  logic        ten;
  logic        acc;
  logic        wr;
  logic        rd_hi;
  logic        rd_lo;
  logic        load;
  logic [4:0]  adr;

  // only the encoding 10 selects ten bits; reserved codes behave as eight-bit
  assign ten = (s_q.cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_TEN_BIT);

  // a request is taken once, in the idle phase; ack follows at the next edge
  assign adr   = {wb_adr_i[4:2], 2'h0};
  assign acc   = wb_cyc_i & wb_stb_i & (s_q.bus_st == BUS_IDLE);
  assign wr    = acc & wb_we_i & wb_sel_i[0];
  assign rd_hi = acc & ~wb_we_i & (adr == `ADR_RESULT_HIGH);
  assign rd_lo = acc & ~wb_we_i & (adr == `ADR_RESULT_LOW);

  // a high read in the same cycle as a completion takes the lock first so the
  // two halves software reads always belong to one conversion
  assign load = conv_done_i & ~s_q.lock & ~(rd_hi & ten)
              & (~s_q.cmp_en | cmp_true);

  result_shaper u_shaper (
    .raw_i      (conv_raw_i),
    .ten_bit_i  (ten),
    .cmp_hi_i   (s_q.cmp_hi),
    .cmp_lo_i   (s_q.cmp_lo),
    .cmp_ge_i   (s_q.cmp_ge),
    .res_o      (shaped),
    .cmp_true_o (cmp_true)
  );

  conv_clock_gen u_clkgen (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .src_i      (clk_src_t'(s_q.cfg[`CFG_CLK_MSB:`CFG_CLK_LSB])),
    .div_i      (s_q.cfg[`CFG_DIV_MSB:`CFG_DIV_LSB]),
    .alt_en_i   (alt_clk_en_i),
    .async_en_i (async_clk_en_i),
    .clk_en_o   (converter_clock_en_o)
  );

  // next state of bus handshake, registers, lock and flag
  always_comb begin
    logic [7:0] rmux;
    rmux = 8'h00;
    s_d = s_q;
    s_d.ack = 1'b0;

    // read mux; unmapped words read as zero
    case (adr)
      `ADR_STATUS_CTRL: rmux = {s_q.flag, s_q.irq_en, s_q.cmp_en, s_q.cmp_ge, 4'h0};
      `ADR_RESULT_HIGH: rmux = {6'h00, ten ? s_q.res_hi : 2'h0};
      `ADR_RESULT_LOW:  rmux = s_q.res_lo;
      `ADR_CMP_HIGH:    rmux = {6'h00, s_q.cmp_hi};
      `ADR_CMP_LOW:     rmux = s_q.cmp_lo;
      `ADR_CONV_CONFIG: rmux = s_q.cfg;
      `ADR_PIN_SELECT:  rmux = s_q.pins;
      default:          rmux = 8'h00;
    endcase

    case (s_q.bus_st)
      BUS_IDLE: begin
        if (acc) begin
          s_d.bus_st = BUS_ACK;
          s_d.ack    = 1'b1;
          s_d.rdata  = wb_we_i ? 8'h00 : rmux;
        end
      end
      BUS_ACK: begin
        s_d.bus_st = BUS_IDLE;
      end
      default: begin
        s_d.bus_st = BUS_IDLE;
      end
    endcase

    // register writes; result words have no write path
    if (wr) begin
      case (adr)
        `ADR_STATUS_CTRL: begin
          s_d.irq_en = wb_dat_i[`SC_IRQ_EN_BIT];
          s_d.cmp_en = wb_dat_i[`SC_CMP_EN_BIT];
          s_d.cmp_ge = wb_dat_i[`SC_CMP_GE_BIT];
        end
        `ADR_CMP_HIGH:    s_d.cmp_hi = wb_dat_i[1:0];
        `ADR_CMP_LOW:     s_d.cmp_lo = wb_dat_i[7:0];
        `ADR_CONV_CONFIG: s_d.cfg    = wb_dat_i[7:0];
        `ADR_PIN_SELECT:  s_d.pins   = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
    // width flag kept in its own flop so the output pin has no gate after it
    s_d.ten_mode = (s_d.cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_TEN_BIT);

    // lock: set by a ten-bit high read, released by a low read
    if (!ten) begin
      s_d.lock = 1'b0;
    end else if (rd_hi) begin
      s_d.lock = 1'b1;
    end else if (rd_lo) begin
      s_d.lock = 1'b0;
    end

    // flag clears on a low read or a status write; a load in the same cycle wins
    if (rd_lo || (wr && adr == `ADR_STATUS_CTRL)) begin
      s_d.flag = 1'b0;
    end
    if (load) begin
      s_d.res_hi = ten ? shaped[9:8] : 2'h0;
      s_d.res_lo = shaped[7:0];
      s_d.flag   = 1'b1;
    end
    s_d.irq = s_d.flag & s_d.irq_en;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q        <= '0;
      s_q.bus_st <= BUS_IDLE;
      s_q.cfg    <= `RST_CONFIG;
      s_q.cmp_lo <= `RST_CMP;
      s_q.pins   <= `RST_PINS;
      s_q.res_lo <= `RST_RESULT;
    end else begin
      s_q <= s_d;
    end
  end

  // every output but the converter clock enable is a slice of the state register
  assign wb_dat_o             = {24'h000000, s_q.rdata};
  assign wb_ack_o             = s_q.ack;
  assign input_clock_select_o = clk_src_t'(s_q.cfg[`CFG_CLK_MSB:`CFG_CLK_LSB]);
  assign low_power_select_o   = s_q.cfg[`CFG_LOW_PWR_BIT];
  assign long_sample_select_o = s_q.cfg[`CFG_LONG_SMP_BIT];
  assign ten_bit_mode_o       = s_q.ten_mode;
  assign pin_disable_o        = s_q.pins;
  assign complete_irq_o       = s_q.irq;

  // checks on the register behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_hi_zero_eight: assert property (
    (rd_hi && !ten) |=> (wb_ack_o && wb_dat_o == 32'h00000000))
    else $error("result high not zero in eight-bit mode");

  a_load_taken: assert property (
    (conv_done_i && !s_q.lock && !s_q.cmp_en && !(rd_hi && ten))
    |=> (s_q.res_lo == $past(shaped[7:0]) && s_q.flag))
    else $error("completed result not loaded");

  a_compare_keep: assert property (
    (conv_done_i && s_q.cmp_en && !cmp_true)
    |=> ($stable(s_q.res_lo) && $stable(s_q.res_hi)))
    else $error("result changed though compare failed");

  a_lock_set: assert property (
    (rd_hi && ten) |=> s_q.lock)
    else $error("high read in ten-bit mode did not lock");

  a_lock_drop: assert property (
    (s_q.lock && conv_done_i)
    |=> ($stable(s_q.res_lo) && $stable(s_q.res_hi)))
    else $error("result moved while locked");

  a_lock_release: assert property (
    (s_q.lock && rd_lo && !rd_hi) |=> !s_q.lock)
    else $error("low read did not release lock");

  a_no_lock_eight: assert property (
    !ten |=> !s_q.lock)
    else $error("lock held in eight-bit mode");

  a_result_ro: assert property (
    (wr && (adr == `ADR_RESULT_HIGH || adr == `ADR_RESULT_LOW) && !conv_done_i)
    |=> ($stable(s_q.res_lo) && $stable(s_q.res_hi)))
    else $error("result register changed by a write");

  a_pin_write: assert property (
    (wr && adr == `ADR_PIN_SELECT)
    |=> (pin_disable_o == $past(wb_dat_i[7:0])))
    else $error("pin select write not applied");

  a_cfg_fields: assert property (
    (wr && adr == `ADR_CONV_CONFIG)
    |=> (low_power_select_o == $past(wb_dat_i[`CFG_LOW_PWR_BIT])
         && long_sample_select_o == $past(wb_dat_i[`CFG_LONG_SMP_BIT])))
    else $error("config fields not applied");

  a_irq_raise: assert property (
    (load && s_q.irq_en && !(wr && adr == `ADR_STATUS_CTRL))
    |=> (complete_irq_o && s_q.flag))
    else $error("completion interrupt not raised");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_ack_timely: assert property (
    acc |=> wb_ack_o)
    else $error("accepted request not acknowledged next cycle");

  // reads, rounding, compare, configuration and flag behaviour
  a_hi_ten_read: assert property (
    (rd_hi && ten) |=> (wb_dat_o == {30'h0, $past(s_q.res_hi)}))
    else $error("result high read lost its top bits");

  a_low_read: assert property (
    rd_lo |=> (wb_dat_o == {24'h000000, $past(s_q.res_lo)}))
    else $error("result low read returned the wrong byte");

  a_eight_hi_zero: assert property (
    (load && !ten) |=> (s_q.res_hi == 2'h0))
    else $error("eight-bit load left upper result bits set");

  a_eight_free: assert property (
    (conv_done_i && !ten && !s_q.lock && (!s_q.cmp_en || cmp_true))
    |=> (s_q.flag && s_q.res_lo == $past(shaped[7:0])))
    else $error("eight-bit completion was held back");

  a_res_hold: assert property (
    !load |=> ($stable(s_q.res_lo) && $stable(s_q.res_hi)))
    else $error("result registers changed without a load");

  a_cmp_eight: assert property (
    (conv_done_i && !ten)
    |-> (cmp_true == (s_q.cmp_ge ? (shaped[7:0] >= s_q.cmp_lo)
                                 : (shaped[7:0] < s_q.cmp_lo))))
    else $error("eight-bit compare used the high compare bits");

  a_cmp_ten: assert property (
    (conv_done_i && ten)
    |-> (cmp_true == (s_q.cmp_ge ? (shaped >= {s_q.cmp_hi, s_q.cmp_lo})
                                 : (shaped < {s_q.cmp_hi, s_q.cmp_lo}))))
    else $error("ten-bit compare ignored the high compare bits");

  a_round_ten: assert property (
    (conv_done_i && ten && conv_raw_i != 11'h7ff)
    |-> (shaped == conv_raw_i[10:1] + {9'h000, conv_raw_i[0]}))
    else $error("ten-bit result not rounded half up");

  a_round_sat: assert property (
    (conv_done_i && ten && conv_raw_i == 11'h7ff) |-> (shaped == `RES_MAX_TEN))
    else $error("ten-bit rounding wrapped instead of saturating");

  a_round_eight: assert property (
    (conv_done_i && !ten) |-> (shaped[9:8] == 2'h0))
    else $error("eight-bit result spilled into the upper bits");

  a_mode_out: assert property (
    (wr && adr == `ADR_CONV_CONFIG)
    |=> (ten_bit_mode_o == ($past(wb_dat_i[`CFG_MODE_MSB:`CFG_MODE_LSB]) == `MODE_TEN_BIT)))
    else $error("conversion width output does not follow config");

  a_clk_select: assert property (
    (wr && adr == `ADR_CONV_CONFIG)
    |=> (input_clock_select_o == $past(wb_dat_i[`CFG_CLK_MSB:`CFG_CLK_LSB])))
    else $error("input clock select does not follow config");

  a_cfg_keep: assert property (
    !(wr && adr == `ADR_CONV_CONFIG) |=> $stable(s_q.cfg))
    else $error("config changed without a config write");

  a_div_gap: assert property (
    (converter_clock_en_o && s_q.cfg[`CFG_DIV_MSB:`CFG_DIV_LSB] != 2'h0)
    |=> !converter_clock_en_o)
    else $error("divided converter clock pulsed twice in a row");

  a_cmp_ctrl: assert property (
    (wr && adr == `ADR_STATUS_CTRL)
    |=> (s_q.cmp_en == $past(wb_dat_i[`SC_CMP_EN_BIT])
         && s_q.cmp_ge == $past(wb_dat_i[`SC_CMP_GE_BIT])))
    else $error("compare controls not applied");

  a_flag_clear: assert property (
    (rd_lo && !load) |=> !s_q.flag)
    else $error("low read did not clear the completion flag");

  a_flag_wins: assert property (
    load |=> s_q.flag)
    else $error("flag clear beat a completion in the same cycle");

  a_pin_keep: assert property (
    !(wr && adr == `ADR_PIN_SELECT) |=> $stable(pin_disable_o))
    else $error("pin select changed without a write");

  a_write_data_zero: assert property (
    (acc && wb_we_i) |=> (wb_dat_o == 32'h00000000))
    else $error("write acknowledge carried read data");

endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adc_regs_cfg.svh"

module tb_top;
  import adc_regs_pkg::*;

  localparam logic [4:0] SC  = `ADR_STATUS_CTRL;
  localparam logic [4:0] HI  = `ADR_RESULT_HIGH;
  localparam logic [4:0] LO  = `ADR_RESULT_LOW;
  localparam logic [4:0] CVH = `ADR_CMP_HIGH;
  localparam logic [4:0] CVL = `ADR_CMP_LOW;
  localparam logic [4:0] CFG = `ADR_CONV_CONFIG;
  localparam logic [4:0] PS  = `ADR_PIN_SELECT;

  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc       = 1'b0;
  logic        we        = 1'b0;
  logic [4:0]  adr       = 5'h00;
  logic [3:0]  sel       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic        done      = 1'b0;
  logic [10:0] raw       = 11'h000;
  logic        alt_en    = 1'b0;
  logic        asy_en    = 1'b0;
  logic [3:0]  tick      = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ck_en;
  clk_src_t    src;
  logic        lp;
  logic        ls;
  logic        tenb;
  logic        irq;
  logic [7:0]  pins;
  logic [31:0] v;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cnt;

  always #5 sys_clk_i = ~sys_clk_i;

  // alternate source ticks every 4th cycle, async source every 8th
  always @(posedge sys_clk_i) begin
    tick   <= tick + 4'h1;
    alt_en <= (tick[1:0] == 2'h3);
    asy_en <= (tick[2:0] == 3'h7);
  end

  adc_regs_top dut (
    .sys_clk_i            (sys_clk_i),
    .rst_i                (rst_i),
    .wb_cyc_i             (cyc),
    .wb_stb_i             (cyc),
    .wb_we_i              (we),
    .wb_adr_i             (adr),
    .wb_sel_i             (sel),
    .wb_dat_i             (wdat),
    .wb_dat_o             (rdat),
    .wb_ack_o             (ack),
    .conv_done_i          (done),
    .conv_raw_i           (raw),
    .alt_clk_en_i         (alt_en),
    .async_clk_en_i       (asy_en),
    .converter_clock_en_o (ck_en),
    .input_clock_select_o (src),
    .low_power_select_o   (lp),
    .long_sample_select_o (ls),
    .ten_bit_mode_o       (tenb),
    .pin_disable_o        (pins),
    .complete_irq_o       (irq)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one classic cycle; ack is sampled at the edge, so data is taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge sys_clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    v = rdat;
    cyc <= 1'b0;
    if (i >= 20) begin
      err_total++;
      results();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    chk($sformatf("register %h", a), v, {24'h0, e});
  endtask

  // one-cycle completion pulse carrying the raw word
  task automatic conv(input logic [10:0] r);
    @(posedge sys_clk_i);
    done <= 1'b1;
    raw  <= r;
    @(posedge sys_clk_i);
    done <= 1'b0;
  endtask

  // registered levels need a cycle to follow a register write
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // reset values, the unmapped word at 1c included
    for (int a = 0; a < 32; a += 4) rdchk(a[4:0], 8'h00);
    wr(CFG, 8'h90);
    settle();
    chk("low power", lp, 1);
    chk("long sample", ls, 1);
    chk("ten bit", tenb, 0);
    wr(CFG, 8'h0c);
    settle();
    chk("reserved mode", tenb, 0);
    wr(CFG, 8'h08);
    settle();
    chk("ten bit", tenb, 1);
    rdchk(CFG, 8'h08);
    // every source against every divide; window is a multiple of all periods
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(CFG, {1'b0, d[1:0], 3'h0, s[1:0]});
        repeat (64) @(posedge sys_clk_i);
        cnt = 0;
        repeat (128) begin
          @(posedge sys_clk_i);
          #1;
          cnt += ck_en;
        end
        chk("converter ticks", cnt, 128 >> (s + d));
        chk("clock source", src, s);
      end
    end
    wr(PS, 8'ha5);
    bus(1'b1, PS, 8'hff, 4'h0);
    settle();
    chk("pin disable", pins, 8'ha5);
    rdchk(PS, 8'ha5);
    $display("test config done");
    // eight-bit results, no interlock
    wr(CFG, 8'h00);
    conv(11'h0ab);
    rdchk(LO, 8'h56);
    rdchk(HI, 8'h00);
    conv(11'h020);
    rdchk(LO, 8'h10);
    conv(11'h1ff);
    wr(LO, 8'h33);
    rdchk(LO, 8'hff);
    // ten-bit results with the high-then-low interlock
    wr(CFG, 8'h08);
    conv(11'h6a5);
    rdchk(HI, 8'h03);
    conv(11'h100);
    conv(11'h102);
    rdchk(LO, 8'h53);
    conv(11'h100);
    rdchk(HI, 8'h00);
    rdchk(LO, 8'h80);
    conv(11'h7ff);
    wr(HI, 8'h00);
    rdchk(HI, 8'h03);
    rdchk(LO, 8'hff);
    $display("test results done");
    // completion flag and interrupt
    wr(SC, 8'h40);
    conv(11'h002);
    settle();
    chk("complete irq", irq, 1);
    rdchk(SC, 8'hc0);
    rdchk(LO, 8'h01);
    settle();
    chk("irq cleared", irq, 0);
    $display("test flag done");
    // ten-bit compare against 100
    wr(CVH, 8'h01);
    wr(CVL, 8'h00);
    rdchk(CVH, 8'h01);
    wr(SC, 8'h20);
    conv(11'h0fe);
    rdchk(LO, 8'h7f);
    conv(11'h400);
    rdchk(HI, 8'h00);
    rdchk(LO, 8'h7f);
    wr(SC, 8'h30);
    conv(11'h400);
    rdchk(HI, 8'h02);
    rdchk(LO, 8'h00);
    conv(11'h0fe);
    rdchk(LO, 8'h00);
    wr(SC, 8'h00);
    conv(11'h0fe);
    rdchk(LO, 8'h7f);
    // eight-bit compare must ignore the high compare bits
    wr(CVH, 8'h03);
    wr(CVL, 8'h40);
    wr(CFG, 8'h00);
    wr(SC, 8'h30);
    conv(11'h0a0);
    rdchk(LO, 8'h50);
    conv(11'h040);
    rdchk(LO, 8'h50);
    $display("test compare done");
    results();
  end
endmodule
`default_nettype wire
